/* pkg/dpc_pkg.sv */
/*
 * dpc_pkg: constants and types shared by the dual position capture unit.
 * assumes: parameter addresses are 16-bit word addresses, each parameter
 * carried as one 32-bit word on the parameter access port.
 */
package dpc_pkg;

    localparam int unsigned DPC_MAX_CH = 2;

    typedef enum logic [1:0]
    {
        DPC_MODE_STOP = 2'b00,
        DPC_MODE_ONCE = 2'b01,
        DPC_MODE_CONT = 2'b10
    } dpc_mode_t;

    localparam logic [31:0] DPC_ACT_MAX  = 32'h0000_0002;
    localparam logic [31:0] DPC_EDGE_MAX = 32'h0000_0001;

    localparam logic       DPC_EDGE_FALL = 1'b0;
    localparam logic       DPC_EDGE_RISE = 1'b1;

    localparam logic [15:0] DPC_OFS_STATUS = 16'h0A02;
    localparam logic [15:0] DPC_OFS_EDGE [DPC_MAX_CH] = '{16'h0A04, 16'h0A06};
    localparam logic [15:0] DPC_OFS_ACT  [DPC_MAX_CH] = '{16'h0A08, 16'h0A0A};
    localparam logic [15:0] DPC_OFS_POS  [DPC_MAX_CH] = '{16'h0A0C, 16'h0A0E};
    localparam logic [15:0] DPC_OFS_CNT  [DPC_MAX_CH] = '{16'h0A10, 16'h0A12};

    localparam logic        DPC_EDGE_RST = 1'b0;
    localparam dpc_mode_t   DPC_MODE_RST = DPC_MODE_STOP;
    localparam logic [15:0] DPC_CNT_RST  = 16'h0000;
    localparam logic [31:0] DPC_POS_RST  = 32'h0000_0000;
    localparam logic [31:0] DPC_RD_NONE  = 32'h0000_0000;

endpackage : dpc_pkg

/* pkg/dpc_chan_if.sv */
/*
 * dpc_chan_if: bundle between the top and one capture channel.
 * assumes: all members except cap_pin are on mclk_i; cap_pin is raw.
 */
`timescale 1ns/1ps
interface dpc_chan_if;
    import dpc_pkg::*;

    logic               cap_pin;
    logic               act_wr;
    dpc_mode_t          act_val;
    logic               edge_wr;
    logic               edge_val;
    logic               ref_shift;
    logic signed [31:0] ref_delta;
    logic signed [31:0] position;
    dpc_mode_t          mode;
    logic               edge_sel;
    logic signed [31:0] latched;
    logic        [15:0] count;
    logic               captured;
    logic               cap_evt;

    modport chan
    (
        input  cap_pin, act_wr, act_val, edge_wr, edge_val,
        input  ref_shift, ref_delta, position,
        output mode, edge_sel, latched, count, captured, cap_evt
    );

    modport ctrl
    (
        output cap_pin, act_wr, act_val, edge_wr, edge_val,
        output ref_shift, ref_delta, position,
        input  mode, edge_sel, latched, count, captured, cap_evt
    );
endinterface : dpc_chan_if

/* design/dpc_capture_chan.sv */
/*
 * dpc_capture_chan: one capture channel (sync, edge detect, latch, count).
 * assumes: writes arrive already range-checked; position is on mclk_i.
 */
`timescale 1ns/1ps
module dpc_capture_chan
(
    input  wire logic mclk_i,
    input  wire logic reset_i,
    dpc_chan_if.chan  ch
);
    import dpc_pkg::*;

    logic               sync1_ff;
    logic               sync2_ff;
    logic               prev_ff;
    dpc_mode_t          mode_ff;
    dpc_mode_t          nxt_mode;
    logic               edge_ff;
    logic signed [31:0] pos_ff;
    logic signed [31:0] nxt_pos;
    logic        [15:0] cnt_ff;
    logic        [15:0] nxt_cnt;
    logic               capd_ff;

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end
        else
        begin
            sync1_ff <= ch.cap_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    wire rise_w  = sync2_ff & ~prev_ff;
    wire fall_w  = ~sync2_ff & prev_ff;
    wire qual_w  = (edge_ff == DPC_EDGE_RISE) ? rise_w : fall_w;
    wire armed_w = (mode_ff != DPC_MODE_STOP);
    wire evt_w   = armed_w & qual_w;
    wire start_w = ch.act_wr & (ch.act_val != DPC_MODE_STOP);

    always_comb
    begin
        nxt_mode = mode_ff;
        if (ch.act_wr)
            nxt_mode = ch.act_val;
        else if (evt_w)
        begin
            unique case (mode_ff)
                DPC_MODE_ONCE: nxt_mode = DPC_MODE_STOP;
                DPC_MODE_CONT: nxt_mode = DPC_MODE_CONT;
                DPC_MODE_STOP: nxt_mode = DPC_MODE_STOP;
                default:       nxt_mode = DPC_MODE_STOP;
            endcase
        end
    end

    assign nxt_pos = evt_w        ? ch.position :
                     ch.ref_shift ? 32'(pos_ff + ch.ref_delta) : pos_ff;

    // count events; start clears, a same-cycle event still counts
    assign nxt_cnt = start_w ? {15'h0000, evt_w} :
                     evt_w   ? 16'(cnt_ff + 16'h0001) : cnt_ff;

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mode_ff <= DPC_MODE_RST;
            edge_ff <= DPC_EDGE_RST;
            pos_ff  <= DPC_POS_RST;
            cnt_ff  <= DPC_CNT_RST;
            capd_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            if (ch.edge_wr)
                edge_ff <= ch.edge_val;
            pos_ff  <= nxt_pos;
            cnt_ff  <= nxt_cnt;
            capd_ff <= evt_w | (capd_ff & ~start_w);
        end
    end

    assign ch.mode     = mode_ff;
    assign ch.edge_sel = edge_ff;
    assign ch.latched  = pos_ff;
    assign ch.count    = cnt_ff;
    assign ch.captured = capd_ff;
    assign ch.cap_evt  = evt_w;

endmodule : dpc_capture_chan

/* design/dpc_capture_top.sv */
/*
 * dpc_capture_top: dual position capture unit behind a parameter port.
 * assumes: a fieldbus agent issues one parameter access per cycle at most,
 * position_i and the reference shift come from logic on mclk_i, and the
 * capture pins are asynchronous.
 */
`timescale 1ns/1ps
module dpc_capture_top
#(
    parameter int unsigned NUM_CH = 2
)
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        first_capture_input_i,
    input  wire logic        second_capture_input_i,
    input  wire logic [31:0] position_i,
    input  wire logic        ref_shift_i,
    input  wire logic [31:0] ref_delta_i,
    input  wire logic [15:0] param_addr_i,
    input  wire logic        param_wr_i,
    input  wire logic        param_rd_i,
    input  wire logic [31:0] param_wdata_i,
    output logic      [31:0] param_rdata_o,
    output logic             param_ack_o,
    output logic             param_err_o,
    output logic      [15:0] captured_status_word_o,
    output logic       [1:0] capture_event_o
);
    import dpc_pkg::*;

    if (NUM_CH < 1 || NUM_CH > dpc_pkg::DPC_MAX_CH)
    begin : g_bad_ch
        $error("dpc_capture_top: NUM_CH must be 1 or 2");
    end

    localparam int unsigned CH = dpc_pkg::DPC_MAX_CH;

    wire [CH-1:0] pins_w = {second_capture_input_i, first_capture_input_i};

    logic [CH-1:0] act_hit;
    logic [CH-1:0] edge_hit;
    logic [CH-1:0] pos_hit;
    logic [CH-1:0] cnt_hit;
    logic [CH-1:0] capd;
    logic [CH-1:0] evt;
    logic [31:0]   rd_word [CH];

    logic          ack_ff;
    logic          err_ff;
    logic [31:0]   rdata_ff;

    wire act_ok_w  = (param_wdata_i <= DPC_ACT_MAX);
    wire edge_ok_w = (param_wdata_i <= DPC_EDGE_MAX);

    dpc_chan_if ch_if [CH] ();

    for (genvar g = 0; g < CH; g++)
    begin : g_ch
        if (g < NUM_CH)
        begin : g_on
            assign act_hit[g]  = (param_addr_i == DPC_OFS_ACT[g]);
            assign edge_hit[g] = (param_addr_i == DPC_OFS_EDGE[g]);
            assign pos_hit[g]  = (param_addr_i == DPC_OFS_POS[g]);
            assign cnt_hit[g]  = (param_addr_i == DPC_OFS_CNT[g]);
        end
        else
        begin : g_off
            assign act_hit[g]  = 1'b0;
            assign edge_hit[g] = 1'b0;
            assign pos_hit[g]  = 1'b0;
            assign cnt_hit[g]  = 1'b0;
        end

        assign ch_if[g].cap_pin   = pins_w[g];
        // only legal commands reach the channel
        assign ch_if[g].act_wr    = param_wr_i & act_hit[g] & act_ok_w;
        assign ch_if[g].act_val   = dpc_mode_t'(param_wdata_i[1:0]);
        assign ch_if[g].edge_wr   = param_wr_i & edge_hit[g] & edge_ok_w;
        assign ch_if[g].edge_val  = param_wdata_i[0];
        assign ch_if[g].ref_shift = ref_shift_i;
        assign ch_if[g].ref_delta = ref_delta_i;
        assign ch_if[g].position  = position_i;

        assign capd[g] = ch_if[g].captured & (g < NUM_CH);
        assign evt[g]  = ch_if[g].cap_evt & (g < NUM_CH);

        assign rd_word[g] = ({32{act_hit[g]}}  & {30'h0, ch_if[g].mode})
                          | ({32{edge_hit[g]}} & {31'h0, ch_if[g].edge_sel})
                          | ({32{pos_hit[g]}}  & ch_if[g].latched)
                          | ({32{cnt_hit[g]}}  & {16'h0000, ch_if[g].count});

        dpc_capture_chan u_chan
        (
            .mclk_i  (mclk_i),
            .reset_i (reset_i),
            .ch      (ch_if[g])
        );
    end

    wire status_hit_w = (param_addr_i == DPC_OFS_STATUS);
    wire ro_hit_w     = status_hit_w | (|pos_hit) | (|cnt_hit);
    wire rw_hit_w     = (|act_hit) | (|edge_hit);
    wire map_hit_w    = ro_hit_w | rw_hit_w;

    // refused writes: read-only, unmapped, or value out of range
    wire wr_bad_w = ~map_hit_w
                  | ro_hit_w
                  | ((|act_hit) & ~act_ok_w)
                  | ((|edge_hit) & ~edge_ok_w);

    wire [15:0] status_w = {14'h0000, capd};

    wire [31:0] rd_mux_w = rd_word[0]
                         | rd_word[1]
                         | ({32{status_hit_w}} & {16'h0000, status_w});

    wire req_w   = param_wr_i | param_rd_i;
    wire nxt_err = param_wr_i ? wr_bad_w : (param_rd_i & ~map_hit_w);

    // response one cycle after request; writes leave rdata holding the last read word
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ack_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= DPC_RD_NONE;
        end
        else
        begin
            ack_ff   <= req_w;
            err_ff   <= req_w & nxt_err;
            if (param_rd_i & ~param_wr_i)
                rdata_ff <= rd_mux_w;
        end
    end

    assign param_ack_o            = ack_ff;
    assign param_err_o            = err_ff;
    assign param_rdata_o          = rdata_ff;
    assign captured_status_word_o = status_w;
    assign capture_event_o        = evt;

endmodule : dpc_capture_top

/* test/dpc_pin_model.sv */
/* dpc_pin_model: far-side source of both capture pins.
   assumes: levels requested on mclk_i edges; pins move off-edge. */
`timescale 1ns/1ps
module dpc_pin_model
(
    input  wire logic [1:0] lvl_i,
    output wire logic       first_o,
    output wire logic       second_o
);
    // 7 ns lag keeps pin changes clear of the sampling edge
    assign #7 first_o  = lvl_i[0];
    assign #7 second_o = lvl_i[1];
endmodule : dpc_pin_model

/* test/dpc_capture_checker.sv */
/* dpc_capture_checker: port assertions for the capture unit.
   assumes: bound to dpc_capture_top; one clock domain. */
`timescale 1ns/1ps
module dpc_capture_checker
#(
    parameter int unsigned NUM_CH = 2
)
(
    input wire logic        mclk_i,
    input wire logic        reset_i,
    input wire logic        first_capture_input_i,
    input wire logic [15:0] param_addr_i,
    input wire logic        param_wr_i,
    input wire logic        param_rd_i,
    input wire logic [31:0] param_wdata_i,
    input wire logic        param_ack_o,
    input wire logic        param_err_o,
    input wire logic [15:0] captured_status_word_o,
    input wire logic  [1:0] capture_event_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wire st = param_wr_i | param_rd_i;
    wire wr = param_wr_i;
    wire [15:0] a = param_addr_i;
    ack_next_a: assert property (st |=> param_ack_o)
        else $error("ack missing");
    ack_cause_a: assert property (param_ack_o |-> $past(st))
        else $error("ack without access");
    ro_count_a: assert property (wr && a == 16'h0A10 |=> param_err_o)
        else $error("count write taken");
    act_range_a: assert property (wr && a == 16'h0A08 && param_wdata_i > 32'h2 |=> param_err_o)
        else $error("bad activation taken");
    edge_range_a: assert property (wr && a == 16'h0A04 && param_wdata_i > 32'h1 |=> param_err_o)
        else $error("bad edge select taken");
    status_top_a: assert property (captured_status_word_o[15:2] == 14'h0)
        else $error("status spare bits set");
    evt_status_a: assert property (capture_event_o[0] |=> captured_status_word_o[0])
        else $error("status not set");
    evt_sync_a: assert property (capture_event_o[0] |-> $past(first_capture_input_i, 2) != $past(first_capture_input_i, 3))
        else $error("event without edge");
    evt_once_a: assert property (capture_event_o[0] |=> !capture_event_o[0])
        else $error("event too long");
    cover property (capture_event_o[0]);
    cover property (capture_event_o[1]);
    cover property (param_err_o);
endmodule : dpc_capture_checker

bind dpc_capture_top dpc_capture_checker #(.NUM_CH(NUM_CH)) u_chk
(.mclk_i, .reset_i, .first_capture_input_i, .param_addr_i, .param_wr_i, .param_rd_i,
 .param_wdata_i, .param_ack_o, .param_err_o, .captured_status_word_o, .capture_event_o);

/* test/dpc_capture_top_tb.sv */
/* dpc_capture_top_tb: self-checking bench for the capture unit.
   assumes: dpc_pin_model drives the pins; bench acts as fieldbus. */
`timescale 1ns/1ps
module dpc_capture_top_tb;
    import dpc_pkg::*;
    logic        mclk_i = 1'b0, reset_i = 1'b1, shf = 1'b0, wr = 1'b0, rq = 1'b0;
    logic [1:0]  lvl = 2'b00;
    logic [31:0] pos = 32'h0, dlt = 32'h0, wd = 32'h0, rd;
    logic [15:0] ad = 16'h0, sts, ew = 16'h0;
    logic [1:0]  pin, ev;
    logic        ak, er;
    int          n_mismatch = 0, n_compared = 0, seed = 20271;
    int          n_ev [2] = '{0, 0};
    logic [31:0] p_ev [2];
    dpc_pin_model u_pin (.lvl_i(lvl), .first_o(pin[0]), .second_o(pin[1]));
    dpc_capture_top #(.NUM_CH(2)) DUT
    (.mclk_i(mclk_i), .reset_i(reset_i), .first_capture_input_i(pin[0]),
     .second_capture_input_i(pin[1]), .position_i(pos), .ref_shift_i(shf),
     .ref_delta_i(dlt), .param_addr_i(ad), .param_wr_i(wr), .param_rd_i(rq),
     .param_wdata_i(wd), .param_rdata_o(rd), .param_ack_o(ak), .param_err_o(er),
     .captured_status_word_o(sts), .capture_event_o(ev));
    always #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i) pos <= $random(seed);
    // negedge: event pulse and position both settled
    always @(negedge mclk_i)
        for (int k = 0; k < 2; k++)
            if (ev[k] === 1'b1)
            begin
                n_ev[k]++;
                p_ev[k] = pos;
            end
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, ee);
        @(posedge mclk_i);
        wr <= w;
        rq <= !w;
        ad <= a;
        wd <= d;
        @(posedge mclk_i);
        wr <= 1'b0;
        rq <= 1'b0;
        #1;
        chk("ack", 1, ak);
        chk("err", ee, er);
    endtask : acc
    task automatic rdc(input logic [15:0] a, input logic [31:0] e);
        acc(0, a, 0, 0);
        chk("rdata", e, rd);
    endtask : rdc
    task automatic drv(input int c, input logic v);
        @(posedge mclk_i);
        lvl[c] <= v;
        repeat (6) @(posedge mclk_i);
    endtask : drv
    function automatic int fires(input int m, input logic es, lv);
        return (m != 0 && es == lv) ? 1 : 0;
    endfunction : fires
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        int k, o;
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            rdc(DPC_OFS_EDGE[c], 0);
            rdc(DPC_OFS_ACT[c], 0);
            rdc(DPC_OFS_POS[c], 0);
            rdc(DPC_OFS_CNT[c], 0);
        end
        rdc(DPC_OFS_STATUS, 0);
        acc(0, 16'h0A00, 0, 1);
        acc(1, DPC_OFS_POS[0], 5, 1);
        acc(1, DPC_OFS_CNT[0], 5, 1);
        acc(1, DPC_OFS_CNT[1], 5, 1);
        acc(1, DPC_OFS_ACT[0], 3, 1);
        acc(1, DPC_OFS_EDGE[0], 2, 1);
        acc(1, DPC_OFS_EDGE[1], 2, 1);
        rdc(DPC_OFS_ACT[0], 0);
        rdc(DPC_OFS_EDGE[0], 0);
        rdc(DPC_OFS_CNT[0], 0);
        rdc(DPC_OFS_POS[0], 0);
        for (int c = 0; c < 2; c++)
            for (int es = 0; es < 2; es++)
                for (int m = 1; m < 3; m++)
                begin
                    o = n_ev[1 - c];
                    acc(1, DPC_OFS_EDGE[c], es, 0);
                    drv(c, !es);
                    acc(1, DPC_OFS_ACT[c], m, 0);
                    rdc(DPC_OFS_CNT[c], 0);
                    k = n_ev[c];
                    drv(c, es);
                    chk("events", k + fires(m, es, es), n_ev[c]);
                    ew[c] = 1'b1;
                    chk("status", ew, sts);
                    rdc(DPC_OFS_POS[c], p_ev[c]);
                    rdc(DPC_OFS_ACT[c], m == 1 ? 0 : 2);
                    drv(c, !es);
                    drv(c, es);
                    chk("events", k + m, n_ev[c]);
                    rdc(DPC_OFS_CNT[c], m);
                    @(posedge mclk_i);
                    dlt <= $random(seed);
                    shf <= 1'b1;
                    @(posedge mclk_i);
                    shf <= 1'b0;
                    rdc(DPC_OFS_POS[c], p_ev[c] + dlt);
                    acc(1, DPC_OFS_ACT[c], 0, 0);
                    drv(c, !es);
                    drv(c, es);
                    chk("events", k + m, n_ev[c]);
                    chk("other", o, n_ev[1 - c]);
                end
        give_verdict();
    end
endmodule : dpc_capture_top_tb
